/* logic/rtes_map.vh */
`ifndef RTES_MAP_VH
`define RTES_MAP_VH

// register offsets (byte addresses, one aligned word each)
`define RTES_ADDR_W          8
`define RTES_REGION_SEL      3'h0
`define RTES_REGION_COUNTER_CONFIGURATION_CONTROL     3'h1
`define RTES_REGION_CTR      3'h2
`define RTES_OFS_RETIRE_SEL0 8'h00
`define RTES_OFS_RENAME_SEL0 8'h10
`define RTES_OFS_CCCR12      8'h20
`define RTES_OFS_CTR12       8'h40
`define RTES_NUM_SEL         6
`define RTES_NUM_CTR         6

// event selection control fields
`define RTES_EVSEL_HI        31
`define RTES_EVSEL_LO        25
`define RTES_MASK_HI         24
`define RTES_MASK_LO         9

// counter configuration control fields
`define RTES_CSEL_HI         15
`define RTES_CSEL_LO         13
`define RTES_COUNTER_CONFIGURATION_CONTROL_EN_BIT     12
`define RTES_COUNTER_CONFIGURATION_CONTROL_PRECISE    0

// event select codes
`define RTES_EV_UOPS         7'h01
`define RTES_EV_INSTR        7'h02
`define RTES_EV_UOP_TYPE     7'h02
`define RTES_EV_BRANCH       7'h06

// counter configuration select codes
`define RTES_CSEL_RETIRE     3'h4
`define RTES_CSEL_RETIRE_HI  3'h5
`define RTES_CSEL_RENAME     3'h2

// mask bit positions for micro-op kind tagging
`define RTES_LOAD_TAG_BIT    1
`define RTES_STORE_TAG_BIT   2

// reset values
`define RTES_SEL_RESET       32'h00000000
`define RTES_COUNTER_CONFIGURATION_CONTROL_RESET      32'h00000000
`define RTES_CTR_RESET       32'h00000000

`endif

/* logic/rtes_counter.v */
`timescale 1ns/100ps
`include "rtes_map.vh"

module rtes_counter #(
    parameter W  = 32,
    parameter CW = 4
) (
    // clock and control
    input  wire          core_clk,
    input  wire          srst,
    input  wire          ce,
    // software preset
    input  wire          load,
    input  wire [W-1:0]  load_val,
    // per-cycle increment
    input  wire [CW-1:0] inc,
    output reg  [W-1:0]  value_q
);

    // a software preset wins over an increment in the same cycle
    always @(posedge core_clk) begin
        if (srst) begin
            value_q <= `RTES_CTR_RESET;
        end else if (ce) begin
            if (load) begin
                value_q <= load_val;
            end else begin
                value_q <= value_q + {{(W-CW){1'b0}}, inc};
            end
        end
    end

endmodule

/* logic/rtes_match.v */
`timescale 1ns/100ps
`include "rtes_map.vh"

module rtes_match #(
    parameter SLOTS     = 3,
    parameter CW        = 4,
    parameter RETIRE_OK = 1,
    parameter BRANCH_OK = 0
) (
    // selection from one event selection control register
    input  wire [6:0]       code,
    input  wire [3:0]       mask,
    // retirement slots of this cycle
    input  wire [SLOTS-1:0] valid,
    input  wire [SLOTS-1:0] instr_end,
    input  wire [SLOTS-1:0] squashed,
    input  wire [SLOTS-1:0] fe_tagged,
    input  wire [SLOTS-1:0] branch,
    input  wire [SLOTS-1:0] taken,
    input  wire [SLOTS-1:0] mispred,
    output reg  [CW-1:0]    cnt
);

    reg [SLOTS-1:0] hits;
    integer         i;

    function [CW-1:0] popc;
        input [SLOTS-1:0] v;
        integer           k;
        begin
            popc = {CW{1'b0}};
            for (k = 0; k < SLOTS; k = k + 1) begin
                popc = popc + {{(CW-1){1'b0}}, v[k]};
            end
        end
    endfunction

    // each slot qualifies on its own; the sum lets several retire per cycle
    always @* begin
        hits = {SLOTS{1'b0}};
        for (i = 0; i < SLOTS; i = i + 1) begin
            if (RETIRE_OK != 0 && code == `RTES_EV_INSTR) begin
                // a restarted complex flow may mark its end twice; counted as seen
                hits[i] = valid[i] & instr_end[i] & mask[{squashed[i], fe_tagged[i]}];
            end else if (RETIRE_OK != 0 && code == `RTES_EV_UOPS) begin
                hits[i] = valid[i] & mask[{1'b0, squashed[i]}];
            end else if (BRANCH_OK != 0 && code == `RTES_EV_BRANCH) begin
                hits[i] = valid[i] & branch[i] & mask[{taken[i], mispred[i]}];
            end
        end
        cnt = popc(hits);
    end

endmodule

/* logic/rtes_top.v */
// Overview of operation
// - selected instruction event counts retiring instructions, qualified by squash and tag masks
// - instruction event is code 02H in bits 31:25, config select 04H, four masks
// - count may depend on pipeline state when counting becomes enabled
// - interrupted complex instruction flows may be counted more than once
// - micro-op event is code 01H, select 04H; mask bit0 valid, bit1 squashed
// - renamer code 02H with select 02H tags load and store micro-ops
// - in tagging event, mask bit1 tags loads and mask bit2 tags stores
// - load and store tag bits never make any counter increment
// - branch event, code 06H, counts retiring branch instructions
// - branch mask bits 0-3: not-taken ok, not-taken miss, taken ok, taken miss
// - any combination of branch mask bits counts every matching branch
// - selectors 0,2 feed counters 12,13,16; selectors 1,3 feed 14,15,17
// - branch only on retire selectors 2,3; retire events 0,1; tagging renamer 0,1
`timescale 1ns/100ps
`include "rtes_map.vh"

module rtes_top #(
    parameter SLOTS = 3,
    parameter CTR_W = 32
) (
    // clock, reset, clock enable
    input  wire             core_clk,
    input  wire             srst,
    input  wire             ce,
    // apb slave
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [7:0]       paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    // retirement pipeline slots
    input  wire [SLOTS-1:0] ret_valid,
    input  wire [SLOTS-1:0] ret_instr_end,
    input  wire [SLOTS-1:0] ret_squashed,
    input  wire [SLOTS-1:0] ret_fe_tagged,
    input  wire [SLOTS-1:0] ret_branch,
    input  wire [SLOTS-1:0] ret_taken,
    input  wire [SLOTS-1:0] ret_mispred,
    // renamer slots
    input  wire [SLOTS-1:0] ren_valid,
    input  wire [SLOTS-1:0] ren_load,
    input  wire [SLOTS-1:0] ren_store,
    // micro-op kind tags towards the retirement tagging logic
    output reg  [SLOTS-1:0] load_tag_q,
    output reg  [SLOTS-1:0] store_tag_q
);

    localparam CW = $clog2(SLOTS + 1);

    // selectors 0..3 are the retire unit, 4..5 the renamer
    reg  [31:0]      sel_q  [0:`RTES_NUM_SEL-1];
    reg  [31:0]      counter_configuration_control_q [0:`RTES_NUM_CTR-1];
    wire [CTR_W-1:0] ctr_val [0:`RTES_NUM_CTR-1];
    wire [CW-1:0]    mcnt   [0:3];
    reg  [CW-1:0]    inc    [0:`RTES_NUM_CTR-1];
    reg  [`RTES_NUM_CTR-1:0] ctr_load;

    reg  [31:0]      rdata_d;
    reg              err_d;
    reg              hit_sel;
    reg              hit_counter_configuration_control;
    reg              hit_ctr;
    reg  [2:0]       idx;
    reg  [SLOTS-1:0] load_tag_d;
    reg  [SLOTS-1:0] store_tag_d;
    wire             acc_first;
    wire             acc_done;
    integer          i;

    // counters 14, 15 and 17 (indices 2, 3, 5) belong to the odd selectors
    function grp_of;
        input integer k;
        begin
            grp_of = (k == 2) || (k == 3) || (k == 5);
        end
    endfunction

    // ---- apb handshake ----
    // one wait state: pready rises on the second access cycle, so read data
    // and the error flag can come from flops with no combinational path out
    assign acc_first = psel & penable & ~pready;
    assign acc_done  = psel & penable & pready;

    // address decode, shared by read mux and write strobes
    always @* begin
        idx      = paddr[4:2];
        hit_sel  = (paddr[7:5] == `RTES_REGION_SEL)  && (idx < `RTES_NUM_SEL);
        hit_counter_configuration_control = (paddr[7:5] == `RTES_REGION_COUNTER_CONFIGURATION_CONTROL) && (idx < `RTES_NUM_CTR);
        hit_ctr  = (paddr[7:5] == `RTES_REGION_CTR)  && (idx < `RTES_NUM_CTR);
        if (paddr[1:0] != 2'b00) begin
            hit_sel  = 1'b0;
            hit_counter_configuration_control = 1'b0;
            hit_ctr  = 1'b0;
        end
    end

    // read mux; unmapped addresses read zero and flag an error
    always @* begin
        rdata_d = 32'h00000000;
        err_d   = 1'b0;
        if (hit_sel) begin
            rdata_d = sel_q[idx];
        end else if (hit_counter_configuration_control) begin
            rdata_d = counter_configuration_control_q[idx];
        end else if (hit_ctr) begin
            rdata_d = ctr_val[idx][31:0];
        end else begin
            err_d = 1'b1;
        end
    end

    // handshake flops; data and error are captured on the first access cycle
    always @(posedge core_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (ce) begin
            pready <= acc_first;
            if (acc_first) begin
                pslverr <= err_d;
                prdata  <= pwrite ? 32'h00000000 : rdata_d;
            end else begin
                pslverr <= 1'b0;
                prdata  <= 32'h00000000;
            end
        end
    end

    // ---- selection and configuration registers ----
    // writes take effect only at the completing edge of the access phase
    always @(posedge core_clk) begin
        if (srst) begin
            for (i = 0; i < `RTES_NUM_SEL; i = i + 1) begin
                sel_q[i] <= `RTES_SEL_RESET;
            end
            for (i = 0; i < `RTES_NUM_CTR; i = i + 1) begin
                counter_configuration_control_q[i] <= `RTES_COUNTER_CONFIGURATION_CONTROL_RESET;
            end
        end else if (ce && acc_done && pwrite) begin
            if (hit_sel) begin
                sel_q[idx] <= pwdata;
            end
            if (hit_counter_configuration_control) begin
                // precise sampling bit is stored for software only
                counter_configuration_control_q[idx] <= pwdata;
            end
        end
    end

    // software preset strobes for the counters
    always @* begin
        ctr_load = {`RTES_NUM_CTR{1'b0}};
        if (acc_done && pwrite && hit_ctr) begin
            ctr_load[idx] = 1'b1;
        end
    end

    // ---- event matching, one per retire unit selector ----
    // the two low selectors only know instruction and micro-op events, the
    // two high ones only the branch event; anything else counts nothing
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_match
            rtes_match #(
                .SLOTS     (SLOTS),
                .CW        (CW),
                .RETIRE_OK ((g < 2) ? 1 : 0),
                .BRANCH_OK ((g >= 2) ? 1 : 0)
            ) u_match (
                .code      (sel_q[g][`RTES_EVSEL_HI:`RTES_EVSEL_LO]),
                .mask      (sel_q[g][`RTES_MASK_LO+3:`RTES_MASK_LO]),
                .valid     (ret_valid),
                .instr_end (ret_instr_end),
                .squashed  (ret_squashed),
                .fe_tagged (ret_fe_tagged),
                .branch    (ret_branch),
                .taken     (ret_taken),
                .mispred   (ret_mispred),
                .cnt       (mcnt[g])
            );
        end
    endgenerate

    // ---- counter steering ----
    // the configuration select picks the event source among the counter's
    // own bound selectors; the renamer select yields no increment at all
    always @* begin
        for (i = 0; i < `RTES_NUM_CTR; i = i + 1) begin
            inc[i] = {CW{1'b0}};
            if (counter_configuration_control_q[i][`RTES_COUNTER_CONFIGURATION_CONTROL_EN_BIT]) begin
                case (counter_configuration_control_q[i][`RTES_CSEL_HI:`RTES_CSEL_LO])
                    `RTES_CSEL_RETIRE: begin
                        inc[i] = mcnt[grp_of(i)];
                    end
                    `RTES_CSEL_RETIRE_HI: begin
                        inc[i] = mcnt[2 + grp_of(i)];
                    end
                    `RTES_CSEL_RENAME: begin
                        inc[i] = {CW{1'b0}};
                    end
                    default: begin
                        inc[i] = {CW{1'b0}};
                    end
                endcase
            end
        end
    end

    // counting starts at the first edge after the enable bit is written, so
    // whatever is already in flight decides the first counts
    generate
        for (g = 0; g < `RTES_NUM_CTR; g = g + 1) begin : g_ctr
            rtes_counter #(
                .W        (CTR_W),
                .CW       (CW)
            ) u_ctr (
                .core_clk (core_clk),
                .srst     (srst),
                .ce       (ce),
                .load     (ctr_load[g]),
                .load_val (pwdata[CTR_W-1:0]),
                .inc      (inc[g]),
                .value_q  (ctr_val[g])
            );
        end
    endgenerate

    // ---- micro-op kind tagging from the renamer selectors ----
    // tags only mark micro-ops for other events; they feed no counter here
    always @* begin
        load_tag_d  = {SLOTS{1'b0}};
        store_tag_d = {SLOTS{1'b0}};
        for (i = 4; i < `RTES_NUM_SEL; i = i + 1) begin
            if (sel_q[i][`RTES_EVSEL_HI:`RTES_EVSEL_LO] == `RTES_EV_UOP_TYPE) begin
                if (sel_q[i][`RTES_MASK_LO + `RTES_LOAD_TAG_BIT]) begin
                    load_tag_d = load_tag_d | (ren_valid & ren_load);
                end
                if (sel_q[i][`RTES_MASK_LO + `RTES_STORE_TAG_BIT]) begin
                    store_tag_d = store_tag_d | (ren_valid & ren_store);
                end
            end
        end
    end

    // registered tag outputs
    always @(posedge core_clk) begin
        if (srst) begin
            load_tag_q  <= {SLOTS{1'b0}};
            store_tag_q <= {SLOTS{1'b0}};
        end else if (ce) begin
            load_tag_q  <= load_tag_d;
            store_tag_q <= store_tag_d;
        end
    end

endmodule

/* test/rtes_top_props.sv */
`timescale 1ns/100ps
module rtes_props #(
    parameter SLOTS = 3
) (
    // clock, reset, enable
    input wire             core_clk,
    input wire             srst,
    input wire             ce,
    // apb
    input wire             psel,
    input wire             penable,
    input wire [31:0]      prdata,
    input wire             pready,
    input wire             pslverr,
    // renamer slots and tags
    input wire [SLOTS-1:0] ren_valid,
    input wire [SLOTS-1:0] ren_load,
    input wire [SLOTS-1:0] ren_store,
    input wire [SLOTS-1:0] load_tag_q,
    input wire [SLOTS-1:0] store_tag_q
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (srst);
    // apb phases, only meaningful while the clock enable runs
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && ce;
    endsequence
    property p_answer;
        s_setup ##1 s_access |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer after one wait");
    // a frozen pready may outlive the request, hence the ce guard
    property p_cause;
        pready && $past(ce) |-> $past(psel && penable);
    endproperty
    a_cause: assert property (p_cause) else $error("answer without access");
    property p_pulse;
        pready && ce |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
    property p_idle;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without answer");
    property p_load;
        $past(ce) |-> (load_tag_q & ~$past(ren_valid & ren_load)) == '0;
    endproperty
    a_load: assert property (p_load) else $error("load tag on non-load");
    property p_store;
        $past(ce) |-> (store_tag_q & ~$past(ren_valid & ren_store)) == '0;
    endproperty
    a_store: assert property (p_store) else $error("store tag on non-store");
    property p_hold;
        !ce |=> $stable(load_tag_q) && $stable(store_tag_q);
    endproperty
    a_hold: assert property (p_hold) else $error("tags moved while frozen");
endmodule

bind rtes_top rtes_props #(.SLOTS(SLOTS)) u_rtes_props (
    .core_clk(core_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ren_valid(ren_valid),
    .ren_load(ren_load), .ren_store(ren_store), .load_tag_q(load_tag_q),
    .store_tag_q(store_tag_q));

/* test/rtes_pipe_model.sv */
`timescale 1ns/100ps
module rtes_pipe_model #(
    parameter SLOTS = 3
) (
    // clock and traffic gate
    input  wire              core_clk,
    input  wire              run,
    // retirement and renamer slots
    output logic [SLOTS-1:0] v  = '0,
    output logic [SLOTS-1:0] ie = '0,
    output logic [SLOTS-1:0] sq = '0,
    output logic [SLOTS-1:0] ft = '0,
    output logic [SLOTS-1:0] br = '0,
    output logic [SLOTS-1:0] tk = '0,
    output logic [SLOTS-1:0] mp = '0,
    output logic [SLOTS-1:0] nv = '0,
    output logic [SLOTS-1:0] nl = '0,
    output logic [SLOTS-1:0] ns = '0
);
    // qualifiers churn even on idle slots so stale values never pass as valid
    always @(posedge core_clk) begin
        v  <= run ? SLOTS'($urandom) : '0;
        ie <= SLOTS'($urandom);
        sq <= SLOTS'($urandom);
        ft <= SLOTS'($urandom);
        br <= SLOTS'($urandom);
        tk <= SLOTS'($urandom);
        mp <= SLOTS'($urandom);
        nv <= run ? SLOTS'($urandom) : '0;
        nl <= SLOTS'($urandom);
        ns <= SLOTS'($urandom);
    end
endmodule

/* test/rtes_top_tb.sv */
`timescale 1ns/100ps
module rtes_top_tb;
    localparam SLOTS = 3;
    logic             core_clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic             run = 0, pready, pslverr, er;
    logic [7:0]       paddr = 8'h00;
    logic [31:0]      pwdata = 32'h0, prdata, rd;
    logic [SLOTS-1:0] v, ie, sq, ft, br, tk, mp, nv, nl, ns, lt, st;
    logic [SLOTS-1:0] pl = '0, ps = '0;
    logic [3:0]       m0, m1, m2, m3;
    logic [31:0]      e [0:5];
    integer           failures = 0, cmp_count = 0, cyc = 0, r = 0, i;

    always #50 core_clk = ~core_clk;

    rtes_pipe_model #(.SLOTS(SLOTS)) u_rtes_pipe_model (.core_clk(core_clk), .run(run),
        .v(v), .ie(ie), .sq(sq), .ft(ft), .br(br), .tk(tk), .mp(mp), .nv(nv), .nl(nl), .ns(ns));
    rtes_top #(.SLOTS(SLOTS)) u_rtes_top (.core_clk(core_clk), .srst(srst), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .ret_valid(v),
        .ret_instr_end(ie), .ret_squashed(sq), .ret_fe_tagged(ft), .ret_branch(br),
        .ret_taken(tk), .ret_mispred(mp), .ren_valid(nv), .ren_load(nl), .ren_store(ns),
        .load_tag_q(lt), .store_tag_q(st));

    // qualifying slots this cycle: 0 instructions, 1 micro-ops, 2 branches
    function automatic logic [31:0] nq(input integer k, input logic [3:0] m);
        integer s;
        nq = 0;
        for (s = 0; s < SLOTS; s++) begin
            if (k == 0)
                nq += v[s] & ie[s] & m[{sq[s], ft[s]}];
            else if (k == 1)
                nq += v[s] & m[sq[s]];
            else
                nq += v[s] & br[s] & m[{tk[s], mp[s]}];
        end
    endfunction

    function automatic logic [31:0] ev(input logic [6:0] c, input logic [3:0] m);
        ev = {c, 25'h0} | {19'h0, m, 9'h0};
    endfunction

    function automatic logic [31:0] cc(input logic [2:0] s, input logic en, input logic p);
        cc = {16'h0, s, en, 11'h0, p};
    endfunction

    // reference counts sample the same edges as the design
    always @(posedge core_clk) begin
        if (!srst && ce) begin
            e[0] += nq(0, m0);
            e[1] += nq(2, m2);
            e[2] += nq(1, m1);
            if (r[0])
                e[3] += nq(2, m3);
            // renamer selector 0 tags loads and stores during every round
            if (run) begin
                chk({29'h0, lt}, {29'h0, pl});
                chk({29'h0, st}, {29'h0, ps});
            end
            pl = nv & nl;
            ps = nv & ns;
        end
    end

    // hang guard, well above the roughly 1000 cycles the run needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            complete_run;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        apb(0, a, 32'h0);
        chk(rd, x);
        chk({31'h0, er}, {31'h0, xe});
    endtask

    task complete_run;
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        void'($urandom(98));
        repeat (5) @(posedge core_clk);
        srst <= 0;
        rdchk(8'h40, 32'h0, 0);
        apb(1, 8'h42, 32'h5);
        chk({31'h0, er}, 32'h1);
        rdchk(8'h40, 32'h0, 0);
        rdchk(8'h80, 32'h0, 1);
        // first round opens every retire selector mask, later rounds draw them
        for (r = 0; r < 4; r++) begin
            m0 = r ? 4'($urandom) : 4'hF;
            m1 = r ? 4'($urandom) : 4'hF;
            m2 = r ? 4'($urandom) : 4'hF;
            m3 = r ? 4'($urandom) : 4'hF;
            apb(1, 8'h00, ev(7'h02, m0));
            apb(1, 8'h04, ev(7'h01, m1));
            apb(1, 8'h08, ev(7'h06, m2));
            apb(1, 8'h0C, ev(r[0] ? 7'h06 : 7'h01, m3));
            apb(1, 8'h10, ev(7'h02, 4'h6));
            apb(1, 8'h20, cc(3'h4, 1, r[1]));
            apb(1, 8'h24, cc(3'h5, 1, 0));
            apb(1, 8'h28, cc(3'h4, 1, 0));
            apb(1, 8'h2C, cc(3'h5, 1, 0));
            apb(1, 8'h30, cc(3'h2, 1, 0));
            apb(1, 8'h34, cc(3'h4, 0, 0));
            for (i = 0; i < 6; i++) begin
                apb(1, 8'(8'h40 + 4 * i), 32'h0);
                e[i] = 0;
            end
            rdchk(8'h10, ev(7'h02, 4'h6), 0);
            run <= 1;
            repeat (150) begin
                @(posedge core_clk);
                ce <= ($urandom % 8) != 0;
            end
            @(posedge core_clk);
            run <= 0;
            ce <= 1;
            repeat (3) @(posedge core_clk);
            for (i = 0; i < 6; i++)
                rdchk(8'(8'h40 + 4 * i), e[i], 0);
        end
        complete_run;
    end
endmodule
